// ==== include/qse_pkg.sv ====
// Shared constants and types for the fault status and error queue block
package qse_pkg;

  // Widths
  localparam int QSE_REG_W = 16;
  localparam int QSE_MSG_W = 8;
  localparam int QSE_ENTRY_W = QSE_REG_W + QSE_MSG_W;
  localparam int QSE_Q_DEPTH = 8;
  localparam int QSE_PTR_W = 3;

  // Fault bit positions
  localparam int QSE_BIT_OVERVOLTAGE = 0;
  localparam int QSE_BIT_OVERCURRENT = 1;
  localparam int QSE_BIT_LOCAL_KEY = 3;
  localparam int QSE_BIT_OVERTEMP = 4;
  localparam int QSE_BIT_OPEN_SENSE = 5;
  localparam int QSE_BIT_OUT2_UNREG = 8;
  localparam int QSE_BIT_INHIBIT = 9;
  localparam int QSE_BIT_MAIN_UNREG = 10;
  localparam int QSE_BIT_OUT2_OVERCURRENT = 12;
  localparam int QSE_BIT_MEAS_OVERLOAD = 14;

  // Register values
  localparam logic [15:0] QSE_USED_BITS = 16'h573b;
  localparam logic [15:0] QSE_WRITE_MASK = 16'h7fff;
  localparam logic [15:0] QSE_FALL_PRESET = 16'h0000;
  localparam logic [15:0] QSE_RISE_PRESET = 16'h7fff;
  localparam logic [15:0] QSE_MASK_PRESET = 16'h0000;
  localparam logic [15:0] QSE_ZERO16 = 16'h0000;

  // Error codes and message identifiers
  localparam logic [15:0] QSE_CODE_NO_ERROR = 16'h0000;
  localparam logic [15:0] QSE_CODE_TOO_MANY = 16'hfea2;
  localparam logic [7:0] QSE_MSG_NO_ERROR = 8'h00;
  localparam logic [7:0] QSE_MSG_TOO_MANY = 8'h01;

  // Version defaults
  localparam logic [15:0] QSE_VERSION_YEAR = 16'h07d0;
  localparam logic [7:0] QSE_VERSION_REV = 8'h00;

  // Host query and command codes
  typedef enum logic [3:0] {
    QSE_CMD_NONE = 4'b0000,
    QSE_CMD_RD_COND = 4'b0001,
    QSE_CMD_RD_EVENT = 4'b0010,
    QSE_CMD_WR_MASK = 4'b0011,
    QSE_CMD_RD_MASK = 4'b0100,
    QSE_CMD_WR_FALL = 4'b0101,
    QSE_CMD_RD_FALL = 4'b0110,
    QSE_CMD_WR_RISE = 4'b0111,
    QSE_CMD_RD_RISE = 4'b1000,
    QSE_CMD_RD_ERROR = 4'b1001,
    QSE_CMD_RD_VERSION = 4'b1010,
    QSE_CMD_CLEAR = 4'b1011,
    QSE_CMD_PRESET = 4'b1100
  } qse_cmd_t;

  // Error queue state
  typedef struct packed {
    logic [QSE_Q_DEPTH-1:0][QSE_ENTRY_W-1:0] mem;
    logic [QSE_PTR_W-1:0] rd_ptr;
    logic [QSE_PTR_W-1:0] wr_ptr;
    logic [QSE_PTR_W:0] count;
  } qse_queue_state_t;

  // Pointer step with wrap
  function automatic logic [QSE_PTR_W-1:0] qse_ptr_step(input logic [QSE_PTR_W-1:0] p,
                                                        input logic up);
    if (up) begin
      qse_ptr_step = p + 3'd1;
    end else begin
      qse_ptr_step = p - 3'd1;
    end
  endfunction

endpackage

// ==== hw/qse_error_queue.sv ====
// First-in first-out store of remote error entries
`timescale 1ns/1ps
module qse_error_queue
  import qse_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fill side
  input wire logic push,
  input wire logic [QSE_REG_W-1:0] push_code,
  input wire logic [QSE_MSG_W-1:0] push_msg,
  // Drain side
  input wire logic pop,
  input wire logic flush,
  output logic [QSE_REG_W-1:0] head_code,
  output logic [QSE_MSG_W-1:0] head_msg,
  output logic empty
);

  qse_queue_state_t st;
  qse_queue_state_t next_st;
  logic full;
  logic do_pop;

  assign empty = (st.count == '0);
  assign full = (st.count == (QSE_PTR_W+1)'(QSE_Q_DEPTH));
  assign do_pop = pop && !empty;
  assign head_code = st.mem[st.rd_ptr][QSE_ENTRY_W-1:QSE_MSG_W];
  assign head_msg = st.mem[st.rd_ptr][QSE_MSG_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (do_pop) begin
      next_st.rd_ptr = qse_ptr_step(st.rd_ptr, 1'b1);
    end
    if (push && (!full || do_pop)) begin
      next_st.mem[st.wr_ptr] = {push_code, push_msg};
      next_st.wr_ptr = qse_ptr_step(st.wr_ptr, 1'b1);
    end else if (push) begin
      // Newest slot marks the overflow
      next_st.mem[qse_ptr_step(st.wr_ptr, 1'b0)] = {QSE_CODE_TOO_MANY, QSE_MSG_TOO_MANY};
    end
    if (push && !full && !do_pop) begin
      next_st.count = st.count + 4'd1;
    end else if (do_pop && !push) begin
      next_st.count = st.count - 4'd1;
    end
    if (flush) begin
      next_st.rd_ptr = '0;
      next_st.wr_ptr = '0;
      next_st.count = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ==== hw/qse_status_top.sv ====
// Fault condition, event latch, summary and error queue front end
`timescale 1ns/1ps

// Functional notes
// - Event latch holds filtered edges; host cannot write
// - Event read returns value, then clears it
// - Fault flags sit at fixed bit positions
// - Condition read shows live unlatched fault state
// - Host writes summary mask, range 0 to 32767
// - Summary bit is OR of enabled events
// - Falling filter bit captures falling edges
// - Rising filter bit captures rising edges
// - Both filter bits capture either edge
// - No filter bit captures no edge
// - Preset loads falling 0, rising 32767
// - Error queue is FIFO, oldest read first
// - Empty queue read gives code 0, unchanged
// - Overflow puts too-many code in last slot
// - Local panel errors go to display, not queue
// - Version query gives year and revision
module qse_status_top
  import qse_pkg::*;
#(
  parameter logic [15:0] VERSION_YEAR = QSE_VERSION_YEAR,
  parameter logic [7:0] VERSION_REV = QSE_VERSION_REV
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fault flag pins
  input wire logic overvoltage_trip,
  input wire logic overcurrent_trip,
  input wire logic front_panel_local_key,
  input wire logic overtemperature_trip,
  input wire logic open_sense_lead,
  input wire logic second_output_unregulated,
  input wire logic remote_inhibit_active,
  input wire logic main_output_unregulated,
  input wire logic second_output_overcurrent,
  input wire logic measurement_overload,
  // Host query port
  input wire logic cmd_valid,
  input wire qse_cmd_t cmd_op,
  input wire logic [QSE_REG_W-1:0] cmd_wdata,
  output logic resp_valid,
  output logic [QSE_REG_W-1:0] resp_data,
  output logic [QSE_MSG_W-1:0] resp_msg,
  // Error reports
  input wire logic err_valid,
  input wire logic err_local,
  input wire logic [QSE_REG_W-1:0] err_code,
  input wire logic [QSE_MSG_W-1:0] err_msg,
  // Front panel display path
  output logic disp_valid,
  output logic [QSE_REG_W-1:0] disp_code,
  output logic [QSE_MSG_W-1:0] disp_msg,
  // Status byte summary
  output logic fault_summary_bit
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [QSE_REG_W-1:0] sync1;
    logic [QSE_REG_W-1:0] sync2;
    logic [QSE_REG_W-1:0] cond_prev;
    logic [QSE_REG_W-1:0] fault_event_latch;
    logic [QSE_REG_W-1:0] fault_summary_mask;
    logic [QSE_REG_W-1:0] fault_falling_edge_filter;
    logic [QSE_REG_W-1:0] fault_rising_edge_filter;
    logic summary;
    logic resp_valid;
    logic [QSE_REG_W-1:0] resp_data;
    logic [QSE_MSG_W-1:0] resp_msg;
    logic disp_valid;
    logic [QSE_REG_W-1:0] disp_code;
    logic [QSE_MSG_W-1:0] disp_msg;
  } qse_top_state_t;

  qse_top_state_t st;
  qse_top_state_t next_st;

  logic [QSE_REG_W-1:0] fault_pins;
  logic [QSE_REG_W-1:0] fault_condition_live;
  logic [QSE_REG_W-1:0] rise_seen;
  logic [QSE_REG_W-1:0] fall_seen;
  logic [QSE_REG_W-1:0] edge_set;
  logic is_cmd_rd_event;
  logic is_cmd_rd_error;
  logic is_cmd_clear;
  logic q_push;
  logic q_pop;
  logic q_empty;
  logic [QSE_REG_W-1:0] q_head_code;
  logic [QSE_MSG_W-1:0] q_head_msg;

  ////////////////////////////////////////////////////////////////////////
  // Fault pin placement

  always_comb begin
    fault_pins = QSE_ZERO16;
    fault_pins[QSE_BIT_OVERVOLTAGE] = overvoltage_trip;
    fault_pins[QSE_BIT_OVERCURRENT] = overcurrent_trip;
    fault_pins[QSE_BIT_LOCAL_KEY] = front_panel_local_key;
    fault_pins[QSE_BIT_OVERTEMP] = overtemperature_trip;
    fault_pins[QSE_BIT_OPEN_SENSE] = open_sense_lead;
    fault_pins[QSE_BIT_OUT2_UNREG] = second_output_unregulated;
    fault_pins[QSE_BIT_INHIBIT] = remote_inhibit_active;
    fault_pins[QSE_BIT_MAIN_UNREG] = main_output_unregulated;
    fault_pins[QSE_BIT_OUT2_OVERCURRENT] = second_output_overcurrent;
    fault_pins[QSE_BIT_MEAS_OVERLOAD] = measurement_overload;
  end

  // Live condition after synchroniser
  assign fault_condition_live = st.sync2 & QSE_USED_BITS;

  ////////////////////////////////////////////////////////////////////////
  // Transition filters

  // Compare with the value one clock earlier
  assign rise_seen = fault_condition_live & ~st.cond_prev;
  assign fall_seen = ~fault_condition_live & st.cond_prev;

  // Each polarity gated by its own filter; both or none follow
  assign edge_set = (rise_seen & st.fault_rising_edge_filter)
    | (fall_seen & st.fault_falling_edge_filter);

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  assign is_cmd_rd_event = cmd_valid && (cmd_op == QSE_CMD_RD_EVENT);
  assign is_cmd_rd_error = cmd_valid && (cmd_op == QSE_CMD_RD_ERROR);
  assign is_cmd_clear = cmd_valid && (cmd_op == QSE_CMD_CLEAR);

  // Panel errors bypass the remote queue
  assign q_push = err_valid && !err_local;
  // Empty queue is left alone
  assign q_pop = is_cmd_rd_error && !q_empty;

  ////////////////////////////////////////////////////////////////////////
  // Error queue

  qse_error_queue u_queue (
    .clk_sys(clk_sys),
    .reset(reset),
    .push(q_push),
    .push_code(err_code),
    .push_msg(err_msg),
    .pop(q_pop),
    .flush(is_cmd_clear),
    .head_code(q_head_code),
    .head_msg(q_head_msg),
    .empty(q_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;

    // Two-stage pin synchroniser
    next_st.sync1 = fault_pins;
    next_st.sync2 = st.sync1;
    next_st.cond_prev = fault_condition_live;

    // Clearing read or status clear first, then new edges win
    if (is_cmd_rd_event || is_cmd_clear) begin
      next_st.fault_event_latch = QSE_ZERO16;
    end
    next_st.fault_event_latch = next_st.fault_event_latch | edge_set;

    // Host writes
    if (cmd_valid) begin
      case (cmd_op)
        QSE_CMD_WR_MASK: begin
          next_st.fault_summary_mask = cmd_wdata & QSE_WRITE_MASK;
        end
        QSE_CMD_WR_FALL: begin
          next_st.fault_falling_edge_filter = cmd_wdata & QSE_WRITE_MASK;
        end
        QSE_CMD_WR_RISE: begin
          next_st.fault_rising_edge_filter = cmd_wdata & QSE_WRITE_MASK;
        end
        QSE_CMD_PRESET: begin
          next_st.fault_falling_edge_filter = QSE_FALL_PRESET;
          next_st.fault_rising_edge_filter = QSE_RISE_PRESET;
          next_st.fault_summary_mask = QSE_MASK_PRESET;
        end
        default: begin
        end
      endcase
    end

    // Summary from enabled event bits
    next_st.summary = |(next_st.fault_event_latch & next_st.fault_summary_mask);

    // Host answers
    next_st.resp_valid = 1'b0;
    next_st.resp_data = QSE_ZERO16;
    next_st.resp_msg = QSE_MSG_NO_ERROR;
    if (cmd_valid) begin
      case (cmd_op)
        QSE_CMD_RD_COND: begin
          next_st.resp_valid = 1'b1;
          next_st.resp_data = fault_condition_live;
        end
        QSE_CMD_RD_EVENT: begin
          next_st.resp_valid = 1'b1;
          next_st.resp_data = st.fault_event_latch;
        end
        QSE_CMD_RD_MASK: begin
          next_st.resp_valid = 1'b1;
          next_st.resp_data = st.fault_summary_mask;
        end
        QSE_CMD_RD_FALL: begin
          next_st.resp_valid = 1'b1;
          next_st.resp_data = st.fault_falling_edge_filter;
        end
        QSE_CMD_RD_RISE: begin
          next_st.resp_valid = 1'b1;
          next_st.resp_data = st.fault_rising_edge_filter;
        end
        QSE_CMD_RD_ERROR: begin
          next_st.resp_valid = 1'b1;
          if (q_empty) begin
            next_st.resp_data = QSE_CODE_NO_ERROR;
            next_st.resp_msg = QSE_MSG_NO_ERROR;
          end else begin
            next_st.resp_data = q_head_code;
            next_st.resp_msg = q_head_msg;
          end
        end
        QSE_CMD_RD_VERSION: begin
          next_st.resp_valid = 1'b1;
          next_st.resp_data = VERSION_YEAR;
          next_st.resp_msg = VERSION_REV;
        end
        QSE_CMD_WR_MASK, QSE_CMD_WR_FALL, QSE_CMD_WR_RISE,
        QSE_CMD_CLEAR, QSE_CMD_PRESET: begin
          next_st.resp_valid = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Panel errors shown at once
    next_st.disp_valid = err_valid && err_local;
    if (err_valid && err_local) begin
      next_st.disp_code = err_code;
      next_st.disp_msg = err_msg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.fault_falling_edge_filter <= QSE_FALL_PRESET;
      st.fault_rising_edge_filter <= QSE_RISE_PRESET;
      st.fault_summary_mask <= QSE_MASK_PRESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign resp_valid = st.resp_valid;
  assign resp_data = st.resp_data;
  assign resp_msg = st.resp_msg;
  assign disp_valid = st.disp_valid;
  assign disp_code = st.disp_code;
  assign disp_msg = st.disp_msg;
  assign fault_summary_bit = st.summary;

endmodule

// ==== test/qse_status_assertions.sv ====
// Port checker for the fault status and error queue block
`timescale 1ns/1ps
module qse_status_assertions
  import qse_pkg::*;
#(
  parameter logic [15:0] VERSION_YEAR = QSE_VERSION_YEAR,
  parameter logic [7:0] VERSION_REV = QSE_VERSION_REV
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Host port
  input wire logic cmd_valid,
  input wire qse_cmd_t cmd_op,
  input wire logic [QSE_REG_W-1:0] cmd_wdata,
  input wire logic resp_valid,
  input wire logic [QSE_REG_W-1:0] resp_data,
  input wire logic [QSE_MSG_W-1:0] resp_msg,
  // Errors and status
  input wire logic err_valid,
  input wire logic err_local,
  input wire logic disp_valid,
  input wire logic fault_summary_bit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_event_answer: assert property (
    cmd_valid && cmd_op == QSE_CMD_RD_EVENT |=> resp_valid) else $error("no event answer");
  a_cond_unused: assert property (
    cmd_valid && cmd_op == QSE_CMD_RD_COND |=> resp_valid && (resp_data & ~QSE_USED_BITS) == 0)
    else $error("unused condition bit set");
  a_no_stray: assert property (
    !cmd_valid |=> !resp_valid) else $error("answer without command");
  a_local_disp: assert property (
    err_valid && err_local |=> disp_valid) else $error("local error not shown");
  a_remote_quiet: assert property (
    err_valid && !err_local |=> !disp_valid) else $error("remote error shown");
  a_mask_zero: assert property (
    cmd_valid && cmd_op == QSE_CMD_WR_MASK && cmd_wdata == 16'h0000 |=> !fault_summary_bit)
    else $error("summary set with mask zero");
  a_mask_range: assert property (
    cmd_valid && cmd_op == QSE_CMD_RD_MASK |=> !resp_data[15]) else $error("mask bit 15 set");
  a_filter_range: assert property (
    cmd_valid && (cmd_op == QSE_CMD_RD_RISE || cmd_op == QSE_CMD_RD_FALL) |=> !resp_data[15])
    else $error("filter bit 15 set");
  a_version_form: assert property (
    cmd_valid && cmd_op == QSE_CMD_RD_VERSION |=> resp_data == VERSION_YEAR
    && resp_msg == VERSION_REV) else $error("version answer wrong");
endmodule

// ==== test/qse_host_model.sv ====
// Remote host model issuing status and error queries
`timescale 1ns/1ps
module qse_host_model
  import qse_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Query port
  output logic cmd_valid,
  output qse_cmd_t cmd_op,
  output logic [QSE_REG_W-1:0] cmd_wdata,
  input wire logic resp_valid,
  input wire logic [QSE_REG_W-1:0] resp_data,
  input wire logic [QSE_MSG_W-1:0] resp_msg
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = QSE_CMD_NONE;
    cmd_wdata = 16'h0000;
  end
  // One command, one answer
  task automatic xfer(input qse_cmd_t op, input logic [15:0] wd,
                      output logic [15:0] d, output logic [7:0] m);
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wdata = wd & QSE_WRITE_MASK;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    cmd_op = QSE_CMD_NONE;
    cmd_wdata = ~cmd_wdata;
    d = resp_valid ? resp_data : 16'hdead;
    m = resp_msg;
  endtask
endmodule

// ==== test/qse_status_top_tb.sv ====
// Self-checking bench for the fault status and error queue block
`timescale 1ns/1ps
module qse_status_top_tb;
  import qse_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] pins = 16'h0000;
  logic cmd_valid;
  qse_cmd_t cmd_op;
  logic [15:0] cmd_wdata, resp_data, disp_code, rd;
  logic [7:0] resp_msg, disp_msg, rm;
  logic resp_valid, disp_valid, fault_summary_bit;
  logic err_valid = 1'b0;
  logic err_local = 1'b0;
  logic [15:0] err_code = 16'h0000;
  logic [7:0] err_msg = 8'h00;
  int bits[10] = '{0, 1, 3, 4, 5, 8, 9, 10, 12, 14};
  int n_mismatch = 0;
  int n_compared = 0;

  always #20 clk_sys = ~clk_sys;

  qse_host_model qse_host_model_i (.*);
  qse_status_top qse_status_top_i (.*, .overvoltage_trip(pins[0]), .overcurrent_trip(pins[1]),
    .front_panel_local_key(pins[3]), .overtemperature_trip(pins[4]), .open_sense_lead(pins[5]),
    .second_output_unregulated(pins[8]), .remote_inhibit_active(pins[9]),
    .main_output_unregulated(pins[10]), .second_output_overcurrent(pins[12]),
    .measurement_overload(pins[14]));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input qse_cmd_t op, input logic [15:0] wd);
    qse_host_model_i.xfer(op, wd, rd, rm);
  endtask
  task automatic cq(input qse_cmd_t op, input logic [15:0] exp);
    wr(op, 16'h0000);
    chk(op.name(), rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic report(input logic loc, input logic [15:0] c, input logic [7:0] m);
    @(posedge clk_sys);
    #1;
    err_valid = 1'b1;
    err_local = loc;
    err_code = c;
    err_msg = m;
    @(posedge clk_sys);
    #1;
    err_valid = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cq(QSE_CMD_RD_MASK, 16'h0000);
    cq(QSE_CMD_RD_FALL, 16'h0000);
    cq(QSE_CMD_RD_RISE, 16'h7fff);
    cq(QSE_CMD_RD_EVENT, 16'h0000);
    cq(QSE_CMD_RD_ERROR, 16'h0000);
    chk("msg", {8'h00, rm}, {8'h00, QSE_MSG_NO_ERROR});
    cq(QSE_CMD_RD_VERSION, QSE_VERSION_YEAR);
    chk("version rev", {8'h00, rm}, {8'h00, QSE_VERSION_REV});
    $display("test reset done");
  endtask
  task automatic t_rise;
    wr(QSE_CMD_WR_MASK, 16'h0002);
    pins = 16'h0003;
    tick(5);
    chk("summary", {15'h0000, fault_summary_bit}, 16'h0001);
    cq(QSE_CMD_RD_COND, 16'h0003);
    cq(QSE_CMD_RD_EVENT, 16'h0003);
    cq(QSE_CMD_RD_EVENT, 16'h0000);
    chk("summary", {15'h0000, fault_summary_bit}, 16'h0000);
    wr(QSE_CMD_WR_MASK, 16'h0000);
    $display("test rise done");
  endtask
  task automatic t_filters;
    wr(QSE_CMD_WR_RISE, 16'h0010);
    wr(QSE_CMD_WR_FALL, 16'h0011);
    pins = 16'h0010;
    tick(5);
    cq(QSE_CMD_RD_EVENT, 16'h0011);
    pins = 16'h0002;
    tick(5);
    cq(QSE_CMD_RD_EVENT, 16'h0010);
    wr(QSE_CMD_PRESET, 16'h0000);
    cq(QSE_CMD_RD_FALL, 16'h0000);
    cq(QSE_CMD_RD_RISE, 16'h7fff);
    pins = 16'h0000;
    tick(5);
    cq(QSE_CMD_RD_EVENT, 16'h0000);
    $display("test filters done");
  endtask
  task automatic t_bits;
    foreach (bits[i]) begin
      pins = 16'h0001 << bits[i];
      tick(4);
      cq(QSE_CMD_RD_COND, pins);
    end
    pins = 16'h0000;
    tick(4);
    cq(QSE_CMD_RD_EVENT, QSE_USED_BITS);
    $display("test bits done");
  endtask
  task automatic t_queue;
    report(1'b0, 16'h0101, 8'h11);
    report(1'b0, 16'h0102, 8'h12);
    report(1'b1, 16'h0bad, 8'h33);
    chk("disp", {15'h0000, disp_valid}, 16'h0001);
    chk("disp code", disp_code, 16'h0bad);
    chk("disp msg", {8'h00, disp_msg}, 16'h0033);
    cq(QSE_CMD_RD_ERROR, 16'h0101);
    chk("msg", {8'h00, rm}, 16'h0011);
    cq(QSE_CMD_RD_ERROR, 16'h0102);
    cq(QSE_CMD_RD_ERROR, 16'h0000);
    for (int i = 1; i <= 10; i++) report(1'b0, 16'(i), 8'h20);
    for (int i = 1; i <= 7; i++) cq(QSE_CMD_RD_ERROR, 16'(i));
    cq(QSE_CMD_RD_ERROR, QSE_CODE_TOO_MANY);
    chk("msg", {8'h00, rm}, {8'h00, QSE_MSG_TOO_MANY});
    cq(QSE_CMD_RD_ERROR, 16'h0000);
    report(1'b0, 16'h0103, 8'h13);
    pins = 16'h0001;
    tick(4);
    wr(QSE_CMD_CLEAR, 16'h0000);
    chk("clear answer", rd, 16'h0000);
    cq(QSE_CMD_RD_ERROR, 16'h0000);
    cq(QSE_CMD_RD_EVENT, 16'h0000);
    pins = 16'h0000;
    tick(4);
    $display("test queue done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_reset;
    t_rise;
    t_filters;
    t_bits;
    t_queue;
    tally_and_finish;
  end
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule

bind qse_status_top qse_status_assertions #(.VERSION_YEAR(VERSION_YEAR),
  .VERSION_REV(VERSION_REV)) chk_i (
  .clk_sys(clk_sys),
  .reset(reset),
  .cmd_valid(cmd_valid),
  .cmd_op(cmd_op),
  .cmd_wdata(cmd_wdata),
  .resp_valid(resp_valid),
  .resp_data(resp_data),
  .resp_msg(resp_msg),
  .err_valid(err_valid),
  .err_local(err_local),
  .disp_valid(disp_valid),
  .fault_summary_bit(fault_summary_bit)
);
